// file: flash_array_model.sv
// Purpose: behavioural flash array facing the controller
// Assumes: 256 bytes, mirrored over the whole space
// Notes: program ands data in, erase sets a row to ff
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk, // clock
  input wire flash_pkg::flash_cmd_t cmd, // command from controller
  output logic [15:0] rd_word // addressed word
);
  logic [7:0] mem [256];
  logic pp;
  logic pe;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
    rd_word = 16'h0;
    pp = 0;
    pe = 0;
  end
  always @(posedge clk) begin
    pp <= cmd.prog;
    pe <= cmd.erase;
    // idle word keeps changing so a stale read shows
    if (cmd.rd) rd_word <= {mem[{cmd.addr[7:1], 1'b1}], mem[{cmd.addr[7:1], 1'b0}]};
    else rd_word <= ~rd_word;
    if (cmd.prog && !pp)
      for (int i = 0; i < 8; i++) mem[{cmd.addr[7:3], i[2:0]}] &= cmd.data[8*i+:8];
    if (cmd.erase && !pe)
      for (int i = 0; i < 64; i++) mem[{cmd.addr[7:6], i[5:0]}] = 8'hff;
  end
endmodule

// file: flash_pkg.sv
// Purpose: shared constants and types for the program flash self-write controller
// Assumes: 32-bit classic wishbone, 8-bit registers in byte lane 0
// Notes: register offsets are byte addresses
package flash_pkg;
  // ==========================================================
  // pointer and memory geometry
  localparam int PTR_W = 22;
  localparam int LO_W = 21;
  localparam int HOLD_N = 8;
  localparam int HOLD_IDX_W = 3;
  localparam int BLK_LSB = 3;
  localparam int ROW_LSB = 6;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // ==========================================================
  // register map
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_PTR_LOW = 8'h00;
  localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
  localparam logic [7:0] OFS_PTR_UPPER = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam int CTL_PGM = 7;
  localparam int CTL_CFG = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ABORT = 3;
  localparam int CTL_WRITE_ENABLE_BIT = 2;
  localparam int CTL_GO = 1;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam logic [1:0] KEY_IDLE = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_OPEN = 2'h2;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PTR_KEEP = 2'h0,
    PTR_POST_INC = 2'h1,
    PTR_POST_DEC = 2'h2,
    PTR_PRE_INC = 2'h3
  } ptr_mode_t;
  typedef struct packed {
    logic valid;
    logic write;
    ptr_mode_t mode;
  } tbl_cmd_t;
  typedef struct packed {
    logic rd;
    logic prog;
    logic erase;
    logic [PTR_W-1:0] addr;
    logic [HOLD_N*BYTE_W-1:0] data;
  } flash_cmd_t;

  // step only the low pointer bits, top space bit untouched
  function automatic logic [PTR_W-1:0] ptr_adjust(input logic [PTR_W-1:0] p,
                                                  input logic dec);
    logic [LO_W-1:0] lo;
    lo = dec ? p[LO_W-1:0] - {{(LO_W-1){1'b0}}, 1'b1}
             : p[LO_W-1:0] + {{(LO_W-1){1'b0}}, 1'b1};
    return {p[PTR_W-1], lo};
  endfunction
endpackage

// file: program_flash_self_write_ctrl.sv
// Purpose: self-programming controller for on-chip program flash
// Assumes: flash answers a read with flash_rd_word one cycle after rd rises
// Notes: flash array only clears bits that are 0 in the programmed data
`timescale 1ns/1ps
// Summary of operation
// RULE_01: pointer is upper, high and low bytes joined into 22 bits.
// RULE_02: low 21 bits address program memory; top bit selects id/config space.
// RULE_03: table ops keep, post-increment, post-decrement or pre-increment the pointer.
// RULE_04: auto increment and decrement touch only the low 21 pointer bits.
// RULE_05: table read uses all 22 bits and copies the byte to the latch.
// RULE_06: table write stores the latch in holding register picked by bits 2:0.
// RULE_07: programming writes holding registers to 8-byte block at bits 21:3.
// RULE_08: row erase clears 64-byte block at bits 21:6, ignoring bits 5:0.
// RULE_09: memory is 16-bit words; address bit 0 picks high or low byte.
// RULE_10: self erase is always a 64-byte row; no word or bulk erase.
// RULE_11: core loads row address and sets selects and erase before erasing.
// RULE_12: core writes 55h then aah to the key register, then sets go.
// RULE_13: core stalls during timed operation; internal timer ends it after 2 ms.
// RULE_14: smallest programming unit is 8 bytes; no word or byte programming.
// RULE_15: table writes only load holding registers; control write starts programming.
// RULE_16: holding registers reset to ffh on reset and after programming.
// RULE_17: ffh byte leaves target unchanged; programming only clears bits.
// RULE_18: software can set go but not clear it; hardware clears at completion.
// RULE_19: completion sets done flag, held until software clears it.
// RULE_20: reset mid-operation or improper start sets abort flag; selects kept.
// RULE_21: write enable is clear after power-up; nothing starts without it.
// RULE_22: go ignored unless write enable set and both keys came just before.
module program_flash_self_write_ctrl #(
  parameter int PROG_CYCLES = flash_pkg::PROG_CYCLES_DEF
) (
  input wire logic clk, // 200 MHz clock
  input wire logic arst_n, // power-on reset, active low
  input wire logic dev_rst_req, // synchronous device reset request
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [flash_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire flash_pkg::tbl_cmd_t tbl_cmd, // table operation from core
  output logic tbl_done, // table operation finished
  output logic core_stall, // core halted by timed operation
  output flash_pkg::flash_cmd_t flash_cmd, // command to flash array
  input wire logic [flash_pkg::WORD_W-1:0] flash_rd_word // addressed flash word
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RD_WAIT = 4'b0010,
    S_RD_TAKE = 4'b0100,
    S_TIMED = 4'b1000
  } fsm_t;

  fsm_t state_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] latch_reg;
  logic [7:0] hold_reg [flash_pkg::HOLD_N];
  logic pgm_reg, cfg_reg, erase_reg, abort_reg, write_enable_bit_reg, go_reg;
  logic done_reg;
  logic [1:0] key_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic tbl_done_reg;
  logic stall_reg;
  flash_pkg::flash_cmd_t fcmd_reg;
  logic [flash_pkg::HOLD_N*flash_pkg::BYTE_W-1:0] hold_flat;
  logic [flash_pkg::PTR_W-1:0] ptr, eff_ptr;
  logic wr_fire, lane0, tbl_take, go_req, go_ok, finish;
  logic [2:0] ptr_we;

  // ==========================================================
  // wishbone slave: ack one cycle after request, write on the ack edge
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign lane0 = wb_sel_i[0];
  assign ptr_we[0] = wr_fire && lane0 && (wb_adr_i == flash_pkg::OFS_PTR_LOW);
  assign ptr_we[1] = wr_fire && lane0 && (wb_adr_i == flash_pkg::OFS_PTR_HIGH);
  assign ptr_we[2] = wr_fire && lane0 && (wb_adr_i == flash_pkg::OFS_PTR_UPPER);
  assign go_req = wr_fire && lane0 && (wb_adr_i == flash_pkg::OFS_CTRL)
               && wb_dat_i[flash_pkg::CTL_GO] && !go_reg;
  assign go_ok = go_req && write_enable_bit_reg && (key_reg == flash_pkg::KEY_OPEN)
              && (state_reg == S_IDLE); // RULE_22 RULE_21
  assign tbl_take = tbl_cmd.valid && (state_reg == S_IDLE) && !dev_rst_req && !tbl_done_reg;
  assign finish = (state_reg == S_TIMED) && (cnt_reg == '0); // RULE_13

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  always_comb begin
    rdata_next = '0;
    unique case (wb_adr_i)
      flash_pkg::OFS_PTR_LOW: rdata_next[7:0] = ptr[7:0];
      flash_pkg::OFS_PTR_HIGH: rdata_next[7:0] = ptr[15:8];
      flash_pkg::OFS_PTR_UPPER: rdata_next[5:0] = ptr[flash_pkg::PTR_W-1:16];
      flash_pkg::OFS_LATCH: rdata_next[7:0] = latch_reg;
      flash_pkg::OFS_CTRL: begin
        rdata_next[flash_pkg::CTL_PGM] = pgm_reg;
        rdata_next[flash_pkg::CTL_CFG] = cfg_reg;
        rdata_next[flash_pkg::CTL_ERASE] = erase_reg;
        rdata_next[flash_pkg::CTL_ABORT] = abort_reg;
        rdata_next[flash_pkg::CTL_WRITE_ENABLE_BIT] = write_enable_bit_reg;
        rdata_next[flash_pkg::CTL_GO] = go_reg;
      end
      flash_pkg::OFS_STATUS: begin
        rdata_next[flash_pkg::ST_DONE] = done_reg;
        rdata_next[flash_pkg::ST_BUSY] = (state_reg == S_TIMED);
      end
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // table pointer
  table_pointer_unit u_ptr (
    .clk(clk),
    .arst_n(arst_n),
    .byte_we(ptr_we),
    .byte_wdata(wb_dat_i[7:0]),
    .step_en(tbl_take),
    .step_mode(tbl_cmd.mode),
    .ptr(ptr),
    .eff_ptr(eff_ptr)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
    end else if (dev_rst_req) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (go_ok) state_reg <= S_TIMED;
          else if (tbl_take && !tbl_cmd.write) state_reg <= S_RD_WAIT;
        end
        S_RD_WAIT: state_reg <= S_RD_TAKE;
        S_RD_TAKE: state_reg <= S_IDLE;
        S_TIMED: if (finish) state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // self timer, loaded at start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (go_ok) begin
      cnt_reg <= CNT_LAST; // RULE_13
    end else if (state_reg == S_TIMED && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= !dev_rst_req && (go_ok || (state_reg == S_TIMED && !finish)); // RULE_13
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tbl_done_reg <= 1'b0;
    end else begin
      tbl_done_reg <= (tbl_take && tbl_cmd.write)
                   || (state_reg == S_RD_TAKE && !dev_rst_req);
    end
  end

  // ==========================================================
  // flash command: read full pointer, program block, erase row
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fcmd_reg <= '0;
    end else if (dev_rst_req || finish) begin
      fcmd_reg.prog <= 1'b0;
      fcmd_reg.erase <= 1'b0;
      fcmd_reg.rd <= 1'b0;
    end else if (go_ok) begin
      fcmd_reg.prog <= !erase_reg; // RULE_15 RULE_14
      fcmd_reg.erase <= erase_reg; // RULE_10
      if (erase_reg) begin
        fcmd_reg.addr <= {ptr[flash_pkg::PTR_W-1:flash_pkg::ROW_LSB],
                          {flash_pkg::ROW_LSB{1'b0}}}; // RULE_08 RULE_10
      end else begin
        fcmd_reg.addr <= {ptr[flash_pkg::PTR_W-1:flash_pkg::BLK_LSB],
                          {flash_pkg::BLK_LSB{1'b0}}}; // RULE_07
      end
      fcmd_reg.data <= hold_flat; // RULE_17
    end else if (tbl_take && !tbl_cmd.write) begin
      fcmd_reg.rd <= 1'b1;
      fcmd_reg.addr <= eff_ptr; // RULE_05 RULE_02
    end else if (state_reg == S_RD_TAKE) begin
      fcmd_reg.rd <= 1'b0;
    end
  end

  // table latch: hardware read wins over a bus write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= '0;
    end else if (state_reg == S_RD_TAKE && !dev_rst_req) begin
      latch_reg <= fcmd_reg.addr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0]; // RULE_09 RULE_05
    end else if (wr_fire && lane0 && wb_adr_i == flash_pkg::OFS_LATCH) begin
      latch_reg <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // holding registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < flash_pkg::HOLD_N; i++) hold_reg[i] <= flash_pkg::HOLD_RESET; // RULE_16
    end else if (dev_rst_req || (finish && fcmd_reg.prog)) begin
      for (int i = 0; i < flash_pkg::HOLD_N; i++) hold_reg[i] <= flash_pkg::HOLD_RESET; // RULE_16
    end else if (tbl_take && tbl_cmd.write) begin
      hold_reg[eff_ptr[flash_pkg::HOLD_IDX_W-1:0]] <= latch_reg; // RULE_06 RULE_15
    end
  end

  always_comb begin
    for (int i = 0; i < flash_pkg::HOLD_N; i++) begin
      hold_flat[i*flash_pkg::BYTE_W +: flash_pkg::BYTE_W] = hold_reg[i];
    end
  end

  // ==========================================================
  // control register and unlock key
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_reg <= flash_pkg::KEY_IDLE;
    end else if (dev_rst_req) begin
      key_reg <= flash_pkg::KEY_IDLE;
    end else if (wr_fire) begin
      if (lane0 && wb_adr_i == flash_pkg::OFS_KEY) begin
        if (wb_dat_i[7:0] == flash_pkg::KEY_FIRST) key_reg <= flash_pkg::KEY_HALF; // RULE_22
        else if (wb_dat_i[7:0] == flash_pkg::KEY_SECOND && key_reg == flash_pkg::KEY_HALF)
          key_reg <= flash_pkg::KEY_OPEN; // RULE_22
        else key_reg <= flash_pkg::KEY_IDLE;
      end else begin
        key_reg <= flash_pkg::KEY_IDLE; // RULE_22
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pgm_reg <= 1'b0;
      cfg_reg <= 1'b0;
    end else if (wr_fire && lane0 && wb_adr_i == flash_pkg::OFS_CTRL) begin
      pgm_reg <= wb_dat_i[flash_pkg::CTL_PGM];
      cfg_reg <= wb_dat_i[flash_pkg::CTL_CFG];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      write_enable_bit_reg <= 1'b0; // RULE_21
      erase_reg <= 1'b0;
    end else if (dev_rst_req) begin
      write_enable_bit_reg <= 1'b0;
      erase_reg <= 1'b0;
    end else if (finish && fcmd_reg.erase) begin
      erase_reg <= 1'b0;
    end else if (wr_fire && lane0 && wb_adr_i == flash_pkg::OFS_CTRL) begin
      write_enable_bit_reg <= wb_dat_i[flash_pkg::CTL_WRITE_ENABLE_BIT];
      erase_reg <= wb_dat_i[flash_pkg::CTL_ERASE];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      go_reg <= 1'b0;
    end else if (dev_rst_req || finish) begin
      go_reg <= 1'b0; // RULE_18
    end else if (go_ok) begin
      go_reg <= 1'b1; // RULE_18
    end
  end

  // set at start and on improper start, cleared by completion; survives dev reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_reg <= 1'b0;
    end else if (go_req) begin
      abort_reg <= 1'b1; // RULE_20
    end else if (finish && !dev_rst_req) begin
      abort_reg <= 1'b0;
    end else if (wr_fire && lane0 && wb_adr_i == flash_pkg::OFS_CTRL) begin
      abort_reg <= wb_dat_i[flash_pkg::CTL_ABORT];
    end
  end

  // done flag: write one to clear, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else if (finish && !dev_rst_req) begin
      done_reg <= 1'b1; // RULE_19
    end else if (wr_fire && lane0 && wb_adr_i == flash_pkg::OFS_STATUS
                 && wb_dat_i[flash_pkg::ST_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign tbl_done = tbl_done_reg;
  assign core_stall = stall_reg;
  assign flash_cmd = fcmd_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [CNT_W-1:0] len_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) len_reg <= '0;
    else if (state_reg != S_TIMED) len_reg <= '0;
    else len_reg <= len_reg + 1'b1;
  end

  a_timer_length: assert property (finish |-> len_reg == CNT_LAST) // RULE_13
    else $error("timed operation length wrong");
  a_stall_timed: assert property ((state_reg == S_TIMED && !finish && !dev_rst_req) // RULE_13
                                  |=> core_stall)
    else $error("core not stalled during timed operation");
  a_go_self_clear: assert property ((finish && !dev_rst_req) |=> !go_reg && done_reg) // RULE_18
    else $error("go not cleared or done not set at completion");
  a_go_needs_key: assert property ($rose(go_reg) |-> $past(key_reg) == flash_pkg::KEY_OPEN
                                   && $past(write_enable_bit_reg)) // RULE_22
    else $error("go set without unlock or write enable");
  a_abort_on_start: assert property ($rose(go_reg) |-> abort_reg) // RULE_20
    else $error("abort flag not set at start");
  a_erase_row_align: assert property (flash_cmd.erase |-> flash_cmd.addr[5:0] == '0) // RULE_08
    else $error("erase address not row aligned");
  a_prog_blk_align: assert property (flash_cmd.prog |-> flash_cmd.addr[2:0] == '0) // RULE_07
    else $error("program address not block aligned");
  a_hold_reset_after: assert property ((finish && fcmd_reg.prog && !dev_rst_req)
                                       |=> hold_flat == '1) // RULE_16
    else $error("holding registers not restored after programming");
  a_ptr_top_kept: assert property ((tbl_take && !ptr_we[2])
                                   |=> ptr[flash_pkg::PTR_W-1] == $past(ptr[flash_pkg::PTR_W-1])) // RULE_04
    else $error("pointer top bit changed by step");
  a_read_byte_sel: assert property ((state_reg == S_RD_TAKE && !dev_rst_req) |=>
    latch_reg == ($past(fcmd_reg.addr[0]) ? $past(flash_rd_word[15:8])
                                          : $past(flash_rd_word[7:0]))) // RULE_09
    else $error("table latch took wrong byte");

  c_erase_done: cover property (finish && fcmd_reg.erase);
  c_prog_done: cover property (finish && fcmd_reg.prog);
  c_table_read: cover property (state_reg == S_RD_TAKE);
  c_bad_start: cover property (go_req && !go_ok);
endmodule

// file: program_flash_self_write_ctrl_tb.sv
// Purpose: self-checking bench for the flash self-write controller
// Assumes: timed operations shortened to 20 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
module program_flash_self_write_ctrl_tb;
  localparam int PC = 20;
  localparam logic [7:0] LO = flash_pkg::OFS_PTR_LOW;
  localparam logic [7:0] LT = flash_pkg::OFS_LATCH;
  localparam logic [7:0] CT = flash_pkg::OFS_CTRL;
  localparam logic [7:0] ST = flash_pkg::OFS_STATUS;
  logic clk, arst_n, dev_rst_req, cyc, stb, we, ack, done, stall;
  logic [7:0] adr, q;
  logic [31:0] dat, dout;
  logic [15:0] rw;
  flash_pkg::tbl_cmd_t tc;
  flash_pkg::flash_cmd_t fc, cap;
  int failures, comparisons;
  program_flash_self_write_ctrl #(.PROG_CYCLES(PC)) u_program_flash_self_write_ctrl (
    .clk(clk), .arst_n(arst_n), .dev_rst_req(dev_rst_req), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .tbl_cmd(tc), .tbl_done(done), .core_stall(stall), .flash_cmd(fc),
    .flash_rd_word(rw));
  flash_array_model u_flash_array_model (.clk(clk), .cmd(fc), .rd_word(rw));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [7:0] m(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  task automatic summarize;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic tmo;
    failures++;
    $display("CHECK FAILED t=%0t timeout", $time);
    summarize();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) tmo();
    q = dout[7:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic setp(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
    wb(1, flash_pkg::OFS_PTR_UPPER, u);
    wb(1, flash_pkg::OFS_PTR_HIGH, h);
    wb(1, LO, l);
  endtask
  task automatic tbl(input logic w, input flash_pkg::ptr_mode_t md);
    int k;
    k = 0;
    tc <= '{1'b1, w, md};
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 20);
    if (k >= 20) tmo();
    tc <= '0;
    @(posedge clk);
  endtask
  task automatic start(input logic [7:0] c, input logic keys);
    int k;
    k = 0;
    wb(1, CT, c);
    if (keys) begin
      wb(1, flash_pkg::OFS_KEY, flash_pkg::KEY_FIRST);
      wb(1, flash_pkg::OFS_KEY, flash_pkg::KEY_SECOND);
    end
    wb(1, CT, c | 8'h02);
    while (stall !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    cap = fc;
  endtask
  task automatic fin;
    int k;
    k = 0;
    while (stall === 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k >= 200) tmo();
    chk(k >= PC - 2 && k <= PC, 1);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_basic;
    rd(CT, 8'h00);
    rd(ST, 8'h00);
    wb(1, 8'h1c, 8'hff);
    rd(8'h1c, 8'h00);
    setp(8'h3f, 8'hff, 8'hff);
    wb(1, LT, 8'h5a);
    tbl(1, flash_pkg::PTR_POST_INC);
    rd(flash_pkg::OFS_PTR_UPPER, 8'h20);
    rd(LO, 8'h00);
    tbl(1, flash_pkg::PTR_POST_DEC);
    rd(flash_pkg::OFS_PTR_UPPER, 8'h3f);
    rd(flash_pkg::OFS_PTR_HIGH, 8'hff);
  endtask
  task automatic s_read;
    setp(8'h00, 8'h00, 8'h05);
    tbl(0, flash_pkg::PTR_POST_DEC);
    rd(LT, m(8'h05));
    rd(LO, 8'h04);
    tbl(0, flash_pkg::PTR_KEEP);
    rd(LT, m(8'h04));
    rd(LO, 8'h04);
    tbl(0, flash_pkg::PTR_PRE_INC);
    rd(LT, m(8'h05));
    rd(LO, 8'h05);
  endtask
  task automatic s_prog;
    setp(8'h00, 8'h00, 8'h12);
    wb(1, LT, 8'h0f);
    tbl(1, flash_pkg::PTR_KEEP);
    start(8'h84, 1);
    chk(cap.prog, 1);
    chk(cap.addr, 22'h10);
    fin();
    chk(u_flash_array_model.mem[8'h12], m(8'h12) & 8'h0f);
    chk(u_flash_array_model.mem[8'h13], m(8'h13));
    chk(u_flash_array_model.mem[8'h17], m(8'h17) & 8'h5a);
    rd(CT, 8'h84);
    rd(ST, 8'h01);
    wb(1, ST, 8'h01);
    rd(ST, 8'h00);
    start(8'h84, 1);
    chk(cap.data, {64{1'b1}});
    fin();
  endtask
  task automatic s_erase;
    setp(8'h00, 8'h00, 8'h4a);
    start(8'h94, 1);
    chk(cap.erase, 1);
    chk(cap.addr, 22'h40);
    fin();
    chk(u_flash_array_model.mem[8'h7f], 8'hff);
    chk(u_flash_array_model.mem[8'h3f], m(8'h3f));
    rd(CT, 8'h84);
  endtask
  task automatic s_bad;
    start(8'h84, 0);
    chk(stall, 0);
    rd(CT, 8'h8c);
    start(8'h80, 1);
    chk(stall, 0);
    rd(CT, 8'h88);
    start(8'h84, 1);
    chk(stall, 1);
    dev_rst_req <= 1;
    @(posedge clk);
    dev_rst_req <= 0;
    repeat (2) @(posedge clk);
    chk(stall, 0);
    rd(CT, 8'h88);
  endtask
  initial begin
    arst_n = 0;
    dev_rst_req = 0;
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 8'h00;
    dat = 32'h0;
    tc = '0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    s_basic();
    s_read();
    s_prog();
    s_erase();
    s_bad();
    summarize();
  end
endmodule

// file: table_pointer_unit.sv
// Purpose: 22-bit table pointer built of three byte registers with auto update
// Assumes: step_en is a one-cycle pulse per accepted table operation
// Notes: a bus write to a byte wins over a step in the same cycle
`timescale 1ns/1ps
module table_pointer_unit (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [2:0] byte_we, // write strobes: low, high, upper
  input wire logic [7:0] byte_wdata, // byte written by software
  input wire logic step_en, // table operation accepted
  input wire flash_pkg::ptr_mode_t step_mode, // pointer action
  output logic [flash_pkg::PTR_W-1:0] ptr, // current pointer
  output logic [flash_pkg::PTR_W-1:0] eff_ptr // address used by this access
);
  logic [flash_pkg::PTR_W-1:0] ptr_reg;
  logic [flash_pkg::PTR_W-1:0] ptr_next;

  assign ptr = ptr_reg;
  assign eff_ptr = (step_mode == flash_pkg::PTR_PRE_INC)
                 ? flash_pkg::ptr_adjust(ptr_reg, 1'b0) : ptr_reg; // RULE_03

  always_comb begin
    ptr_next = ptr_reg;
    if (step_en) begin
      unique case (step_mode)
        flash_pkg::PTR_KEEP: ptr_next = ptr_reg; // RULE_03
        flash_pkg::PTR_POST_INC: ptr_next = flash_pkg::ptr_adjust(ptr_reg, 1'b0); // RULE_04
        flash_pkg::PTR_POST_DEC: ptr_next = flash_pkg::ptr_adjust(ptr_reg, 1'b1); // RULE_04
        flash_pkg::PTR_PRE_INC: ptr_next = flash_pkg::ptr_adjust(ptr_reg, 1'b0); // RULE_03
      endcase
    end
    // three bytes joined into one pointer
    if (byte_we[0]) ptr_next[7:0] = byte_wdata; // RULE_01
    if (byte_we[1]) ptr_next[15:8] = byte_wdata; // RULE_01
    if (byte_we[2]) ptr_next[flash_pkg::PTR_W-1:16] = byte_wdata[5:0]; // RULE_01
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end
endmodule
